// [mcs_pkg.sv]
// Constants and types shared by the control, status and rate-select register block
package mcs_pkg;

   // ==========================================
   // Serial interface
   localparam logic [6:0] DEV_ADDR       = 7'h51;
   localparam logic [3:0] BYTE_BITS      = 4'h8;

   // ==========================================
   // Register offsets
   localparam logic [7:0] OFF_RXP_HIGH   = 8'h68;
   localparam logic [7:0] OFF_RXP_LOW    = 8'h69;
   localparam logic [7:0] OFF_CTRL       = 8'h6e;
   localparam logic [7:0] OFF_MODE       = 8'h6f;

   // ==========================================
   // Reset values
   localparam logic [7:0] RST_RXP        = 8'h00;
   localparam logic [7:0] RST_MODE       = 8'h00;
   localparam logic       RST_SOFT       = 1'b0;
   localparam logic       RST_POR        = 1'b1;
   localparam logic [7:0] RST_PTR        = 8'h00;

   // ==========================================
   // Control and status field positions
   localparam int         CTRL_TX_OFF    = 7;
   localparam int         CTRL_SOFT_TX   = 6;
   localparam int         CTRL_RATE_B    = 5;
   localparam int         CTRL_RATE_A    = 4;
   localparam int         CTRL_SOFT_RATE = 3;
   localparam int         CTRL_FAULT     = 2;
   localparam int         CTRL_LOST      = 1;
   localparam int         CTRL_POR       = 0;

   // ==========================================
   // Mode control field (bits 7-6 of mode byte)
   localparam int         MODE_HI        = 7;
   localparam int         MODE_LO        = 6;
   localparam logic [1:0] MODE_EMUL      = 2'b00;
   localparam logic [1:0] MODE_HW        = 2'b01;

   // ==========================================
   // Pin synchroniser layout
   localparam int         PIN_W          = 7;
   localparam logic [6:0] PIN_RST        = 7'h60;

   // ==========================================
   // Byte kinds and serial states
   localparam logic [1:0] K_ADDR         = 2'h0;
   localparam logic [1:0] K_WORD         = 2'h1;
   localparam logic [1:0] K_DATA         = 2'h2;

   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_RECV = 5'h02,
      ST_ACK  = 5'h04,
      ST_SEND = 5'h08,
      ST_MACK = 5'h10
   } mcs_ser_st_t;

endpackage

// [mcs_sync.sv]
// Two-stage synchroniser for a group of asynchronous pins
module mcs_sync #(
   parameter int               W         = 1,
   parameter logic [W-1:0]     RESET_VAL = '0
) (
   input  wire logic           clk_i,
   input  wire logic           reset_n_i,
   input  wire logic [W-1:0]   async_i,
   output logic      [W-1:0]   sync_o
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } mcs_sync_st_t;

   mcs_sync_st_t q;
   mcs_sync_st_t d;

   // ==========================================
   // Next state
   always_comb begin
      d    = q;
      d.s1 = async_i;
      d.s2 = q.s1;
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         q <= '{s1: RESET_VAL, s2: RESET_VAL};
      end else begin
         q <= d;
      end
   end

   assign sync_o = q.s2;

endmodule

// [mcs_regs.sv]
// Control, status and rate-select register block behind the two-wire serial slave
import mcs_pkg::*;

// Contract
// - Received power pair reads at 0x68 high, 0x69 low; both reset to zero.
// - Control byte at 0x6e resets to 0x01; only bits 6 and 3 are writable.
// - Bit 7 shows the live transmit-off pin level.
// - Laser is off when soft transmit-off bit or transmit-off pin is high.
// - Bits 5 and 4 show the second and first rate-select input levels.
// - Bit 4 is read-only; host writes to it change nothing.
// - Writable bit 3 is the receive-side soft rate select.
// - Bit 2 shows transmit-fault pin; bit 1 shows receive signal-lost pin.
// - Signal-lost bit tracks the signal-lost pin continuously.
// - Bit 0 reads 1 from power-on until the first full conversion cycle ends.
// - Mode byte at 0x6f is read/write, resets zero; bits 7-6 mode, 5-0 table.
// - Mode 00: receive rate from first input and soft bit; transmit from outside soft bit.
// - Mode 01: outputs follow first and second inputs; soft bits ignored.
// - Mode bit 7 set: neither inputs nor soft bits steer the rate outputs.
// - Stored power is raw in external calibration, corrected result in internal calibration.
module mcs_regs (
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o,
   input  wire logic        tx_off_pin_i,
   input  wire logic        rate_in_a_pin_i,
   input  wire logic        rate_in_b_pin_i,
   input  wire logic        tx_fault_pin_i,
   input  wire logic        rx_signal_lost_pin_i,
   input  wire logic        tx_soft_rate_i,
   input  wire logic        internal_cal_i,
   input  wire logic        adc_cycle_done_i,
   input  wire logic [15:0] rx_power_raw_i,
   input  wire logic [15:0] rx_power_cal_i,
   output logic             tx_laser_off_o,
   output logic             rx_rate_out_pin_o,
   output logic             tx_rate_out_pin_o
);
   import mcs_pkg::*;

   typedef struct packed {
      mcs_ser_st_t st;
      logic [1:0]  kind;
      logic        rw;
      logic        more;
      logic [3:0]  bits;
      logic [7:0]  shift;
      logic [7:0]  ptr;
      logic        scl_prev;
      logic        sda_prev;
      logic        sda_out;
      logic        sda_oe;
      logic [7:0]  rx_power_high;
      logic [7:0]  rx_power_low;
      logic        soft_tx_off;
      logic        soft_rate_a;
      logic [7:0]  rate_select_mode_control;
      logic        por;
      logic        laser_off;
      logic        rx_rate;
      logic        tx_rate;
   } mcs_regs_st_t;

   localparam mcs_regs_st_t ST_RESET = '{
      st:                       ST_IDLE,
      kind:                     K_ADDR,
      rw:                       1'b0,
      more:                     1'b0,
      bits:                     4'h0,
      shift:                    8'h00,
      ptr:                      RST_PTR,
      scl_prev:                 1'b1,
      sda_prev:                 1'b1,
      sda_out:                  1'b0,
      sda_oe:                   1'b0,
      rx_power_high:            RST_RXP,
      rx_power_low:             RST_RXP,
      soft_tx_off:              RST_SOFT,
      soft_rate_a:              RST_SOFT,
      rate_select_mode_control: RST_MODE,
      por:                      RST_POR,
      laser_off:                1'b0,
      rx_rate:                  1'b0,
      tx_rate:                  1'b0
   };

   mcs_regs_st_t     q;
   mcs_regs_st_t     d;
   logic [PIN_W-1:0] pins_s;
   logic             scl_s;
   logic             sda_s;
   logic             tx_off_s;
   logic             rate_a_s;
   logic             rate_b_s;
   logic             fault_s;
   logic             lost_s;
   logic             scl_rise;
   logic             scl_fall;
   logic             start_det;
   logic             stop_det;
   logic             wr_en;
   logic [7:0]       ctrl_rd;
   logic [7:0]       rd_data;
   logic [15:0]      rx_power_sel;
   logic [1:0]       mode_f;

   // ==========================================
   // Pin synchronisers
   mcs_sync #(
      .W         (PIN_W),
      .RESET_VAL (PIN_RST)
   ) u_sync (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .async_i   ({scl_i, sda_i, tx_off_pin_i, rate_in_a_pin_i, rate_in_b_pin_i,
                   tx_fault_pin_i, rx_signal_lost_pin_i}),
      .sync_o    (pins_s)
   );

   assign {scl_s, sda_s, tx_off_s, rate_a_s, rate_b_s, fault_s, lost_s} = pins_s;
   assign mode_f = q.rate_select_mode_control[MODE_HI:MODE_LO];

   // ==========================================
   // Read data
   always_comb begin
      ctrl_rd                 = 8'h00;
      ctrl_rd[CTRL_TX_OFF]    = tx_off_s;
      ctrl_rd[CTRL_SOFT_TX]   = q.soft_tx_off;
      ctrl_rd[CTRL_RATE_B]    = rate_b_s;
      ctrl_rd[CTRL_RATE_A]    = rate_a_s;
      ctrl_rd[CTRL_SOFT_RATE] = q.soft_rate_a;
      ctrl_rd[CTRL_FAULT]     = fault_s;
      ctrl_rd[CTRL_LOST]      = lost_s;
      ctrl_rd[CTRL_POR]       = q.por;
      unique case (q.ptr)
         OFF_RXP_HIGH: rd_data = q.rx_power_high;
         OFF_RXP_LOW:  rd_data = q.rx_power_low;
         OFF_CTRL:     rd_data = ctrl_rd;
         OFF_MODE:     rd_data = q.rate_select_mode_control;
         default:      rd_data = 8'h00;
      endcase
   end

   // ==========================================
   // Next state
   always_comb begin
      d          = q;
      wr_en      = 1'b0;
      scl_rise   = scl_s & ~q.scl_prev;
      scl_fall   = ~scl_s & q.scl_prev;
      start_det  = scl_s & q.scl_prev & q.sda_prev & ~sda_s;
      stop_det   = scl_s & q.scl_prev & ~q.sda_prev & sda_s;
      d.scl_prev = scl_s;
      d.sda_prev = sda_s;
      d.sda_out  = 1'b0;

      rx_power_sel = internal_cal_i ? rx_power_cal_i : rx_power_raw_i;
      if (adc_cycle_done_i) begin
         d.rx_power_high = rx_power_sel[15:8];
         d.rx_power_low  = rx_power_sel[7:0];
         d.por           = 1'b0;
      end

      d.laser_off = tx_off_s | q.soft_tx_off;

      if (!mode_f[1]) begin
         if (mode_f[0]) begin
            d.rx_rate = rate_a_s;
            d.tx_rate = rate_b_s;
         end else begin
            d.rx_rate = rate_a_s | q.soft_rate_a;
            d.tx_rate = tx_soft_rate_i;
         end
      end

      // Serial slave
      if (start_det) begin
         d.st     = ST_RECV;
         d.bits   = 4'h0;
         d.kind   = K_ADDR;
         d.sda_oe = 1'b0;
      end else if (stop_det) begin
         d.st     = ST_IDLE;
         d.sda_oe = 1'b0;
      end else begin
         unique case (q.st)
            ST_IDLE: begin
               d.sda_oe = 1'b0;
            end
            ST_RECV: begin
               if (scl_rise && q.bits != BYTE_BITS) begin
                  d.shift = {q.shift[6:0], sda_s};
                  d.bits  = q.bits + 4'h1;
               end else if (scl_fall && q.bits == BYTE_BITS) begin
                  d.bits = 4'h0;
                  if (q.kind == K_ADDR) begin
                     if (q.shift[7:1] == DEV_ADDR) begin
                        d.rw     = q.shift[0];
                        d.sda_oe = 1'b1;
                        d.st     = ST_ACK;
                     end else begin
                        d.st = ST_IDLE;
                     end
                  end else if (q.kind == K_WORD) begin
                     d.ptr    = q.shift;
                     d.sda_oe = 1'b1;
                     d.st     = ST_ACK;
                  end else begin
                     wr_en    = 1'b1;
                     d.ptr    = q.ptr + 8'h01;
                     d.sda_oe = 1'b1;
                     d.st     = ST_ACK;
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  if (q.rw) begin
                     d.shift  = rd_data;
                     d.ptr    = q.ptr + 8'h01;
                     d.bits   = 4'h1;
                     d.sda_oe = ~rd_data[7];
                     d.st     = ST_SEND;
                  end else begin
                     d.sda_oe = 1'b0;
                     d.bits   = 4'h0;
                     d.kind   = (q.kind == K_ADDR) ? K_WORD : K_DATA;
                     d.st     = ST_RECV;
                  end
               end
            end
            ST_SEND: begin
               if (scl_fall) begin
                  if (q.bits == BYTE_BITS) begin
                     d.sda_oe = 1'b0;
                     d.st     = ST_MACK;
                  end else begin
                     d.shift  = {q.shift[6:0], 1'b0};
                     d.sda_oe = ~q.shift[6];
                     d.bits   = q.bits + 4'h1;
                  end
               end
            end
            ST_MACK: begin
               if (scl_rise) begin
                  d.more = ~sda_s;
               end else if (scl_fall) begin
                  if (q.more) begin
                     d.shift  = rd_data;
                     d.ptr    = q.ptr + 8'h01;
                     d.bits   = 4'h1;
                     d.sda_oe = ~rd_data[7];
                     d.st     = ST_SEND;
                  end else begin
                     d.st = ST_IDLE;
                  end
               end
            end
            default: begin
               d.st     = ST_IDLE;
               d.sda_oe = 1'b0;
            end
         endcase
      end

      // Register writes
      if (wr_en) begin
         if (q.ptr == OFF_CTRL) begin
            d.soft_tx_off = q.shift[CTRL_SOFT_TX];
            d.soft_rate_a = q.shift[CTRL_SOFT_RATE];
         end else if (q.ptr == OFF_MODE) begin
            d.rate_select_mode_control = q.shift;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         q <= ST_RESET;
      end else begin
         q <= d;
      end
   end

   assign sda_o             = q.sda_out;
   assign sda_oe_o          = q.sda_oe;
   assign tx_laser_off_o    = q.laser_off;
   assign rx_rate_out_pin_o = q.rx_rate;
   assign tx_rate_out_pin_o = q.tx_rate;

   // ==========================================
   // Assertions
   sequence tx_off_held;
      tx_off_pin_i [*5];
   endsequence

   sequence lost_high_held;
      rx_signal_lost_pin_i [*4];
   endsequence

   sequence lost_low_held;
      !rx_signal_lost_pin_i [*4];
   endsequence

   sequence rate_a_held;
      rate_in_a_pin_i [*4];
   endsequence

   rxp_zero_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      q.por |-> (q.rx_power_high == 8'h00 && q.rx_power_low == 8'h00))
      else $error("power pair nonzero before first conversion");

   rxp_load_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (adc_cycle_done_i && !internal_cal_i |=> {q.rx_power_high, q.rx_power_low} == $past(rx_power_raw_i))
      and (adc_cycle_done_i && internal_cal_i |=> {q.rx_power_high, q.rx_power_low} == $past(rx_power_cal_i)))
      else $error("power pair not loaded from selected result");

   ctrl_write_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (wr_en && q.ptr == OFF_CTRL) |=> (q.soft_tx_off == $past(q.shift[6])
         && q.soft_rate_a == $past(q.shift[3]) && ctrl_rd[4] == $past(rate_a_s)))
      else $error("control byte write effect wrong");

   laser_pin_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      tx_off_held |-> tx_laser_off_o)
      else $error("laser not off while pin held high");

   laser_soft_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      q.soft_tx_off ##1 q.soft_tx_off |-> tx_laser_off_o)
      else $error("laser not off with soft disable");

   lost_track_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (lost_high_held |-> ctrl_rd[1]) and (lost_low_held |-> !ctrl_rd[1]))
      else $error("loss bit not tracking pin");

   rate_view_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      rate_a_held |-> ctrl_rd[4])
      else $error("first rate input view wrong");

   por_clear_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (adc_cycle_done_i |=> !q.por) and (!q.por |=> !q.por))
      else $error("power-on status bit wrong");

   mode_write_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (wr_en && q.ptr == OFF_MODE) |=> q.rate_select_mode_control == $past(q.shift))
      else $error("mode byte not written");

   mode_emul_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (mode_f == MODE_EMUL) |=> (rx_rate_out_pin_o == ($past(rate_a_s) | $past(q.soft_rate_a))
         && tx_rate_out_pin_o == $past(tx_soft_rate_i)))
      else $error("emulation mode rate outputs wrong");

   mode_hw_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (mode_f == MODE_HW) |=> (rx_rate_out_pin_o == $past(rate_a_s)
         && tx_rate_out_pin_o == $past(rate_b_s)))
      else $error("hardware mode rate outputs wrong");

   mode_sw_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      mode_f[1] |=> ($stable(rx_rate_out_pin_o) && $stable(tx_rate_out_pin_o)))
      else $error("software mode rate outputs moved");

endmodule

// [mcs_host_model.sv]
// Two-wire host controller model driving the register block's serial pins
module mcs_host_model (
   input  wire logic clk_i,
   input  wire logic sda_i,
   input  wire logic slow_i,
   output logic      scl_o,
   output logic      sda_low_o,
   output logic      ack_ok_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import mcs_pkg::*;

   initial begin
      scl_o     = 1'b1;
      sda_low_o = 1'b0;
      ack_ok_o  = 1'b1;
   end

   // ==========================================
   // Bit level, slow host doubles every phase
   task automatic hold(input int n);
      repeat (slow_i ? 2 * n : n) @(posedge clk_i);
   endtask

   task automatic bit_out(input logic b);
      hold(5);
      sda_low_o <= ~b;
      hold(5);
      scl_o <= 1'b1;
      hold(10);
      scl_o <= 1'b0;
   endtask

   task automatic bit_in(output logic b);
      hold(5);
      sda_low_o <= 1'b0;
      hold(5);
      scl_o <= 1'b1;
      hold(10);
      b = sda_i;
      scl_o <= 1'b0;
   endtask

   task automatic start();
      hold(5);
      sda_low_o <= 1'b1;
      hold(10);
      scl_o <= 1'b0;
   endtask

   task automatic rstart();
      hold(5);
      sda_low_o <= 1'b0;
      hold(5);
      scl_o <= 1'b1;
      hold(10);
      sda_low_o <= 1'b1;
      hold(10);
      scl_o <= 1'b0;
   endtask

   task automatic stop();
      hold(5);
      sda_low_o <= 1'b1;
      hold(5);
      scl_o <= 1'b1;
      hold(10);
      sda_low_o <= 1'b0;
      hold(10);
   endtask

   // ==========================================
   // Byte level, any missing ack is remembered
   task automatic byte_out(input logic [7:0] b);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         bit_out(b[i]);
      end
      bit_in(a);
      if (a !== 1'b0) begin
         ack_ok_o <= 1'b0;
      end
   endtask

   task automatic byte_in(output logic [7:0] d);
      for (int i = 7; i >= 0; i--) begin
         bit_in(d[i]);
      end
      bit_out(1'b1);
   endtask

   task automatic wr(input logic [7:0] off, input logic [7:0] data);
      start();
      byte_out({DEV_ADDR, 1'b0});
      byte_out(off);
      byte_out(data);
      stop();
   endtask

   task automatic rd(input logic [7:0] off, output logic [7:0] data);
      start();
      byte_out({DEV_ADDR, 1'b0});
      byte_out(off);
      rstart();
      byte_out({DEV_ADDR, 1'b1});
      byte_in(data);
      stop();
   endtask
endmodule

// [tb_top.sv]
// Self-checking bench for the control, status and rate-select register block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import mcs_pkg::*;

   logic        clk_i, reset_n_i, scl, host_low, slow, ack_ok, sda_o, sda_oe_o;
   logic        tx_off, rate_a, rate_b, fault, lost, tx_soft, int_cal, adc_done;
   logic        laser_off, rx_rate, tx_rate;
   logic [15:0] raw, cal;
   wire         sda_w = ~(host_low | (sda_oe_o & ~sda_o));
   int          checked, fail_count;

   always #5 clk_i = ~clk_i;

   mcs_regs u_mcs_regs (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe_o(sda_oe_o), .tx_off_pin_i(tx_off), .rate_in_a_pin_i(rate_a),
      .rate_in_b_pin_i(rate_b), .tx_fault_pin_i(fault), .rx_signal_lost_pin_i(lost),
      .tx_soft_rate_i(tx_soft), .internal_cal_i(int_cal), .adc_cycle_done_i(adc_done),
      .rx_power_raw_i(raw), .rx_power_cal_i(cal), .tx_laser_off_o(laser_off),
      .rx_rate_out_pin_o(rx_rate), .tx_rate_out_pin_o(tx_rate));

   mcs_host_model u_mcs_host_model (
      .clk_i(clk_i), .sda_i(sda_w), .slow_i(slow), .scl_o(scl), .sda_low_o(host_low),
      .ack_ok_o(ack_ok));

   // ==========================================
   // Compare and access tasks
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp, input string what);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
      end
   endtask

   task automatic rdc(input logic [7:0] off, input logic [7:0] exp, input string what);
      logic [7:0] d;
      u_mcs_host_model.rd(off, d);
      chk8(d, exp, what);
   endtask

   task automatic wr(input logic [7:0] off, input logic [7:0] data);
      u_mcs_host_model.wr(off, data);
      repeat (6) @(posedge clk_i);
   endtask

   task automatic set_pins(input logic [4:0] p);
      @(posedge clk_i);
      {tx_off, rate_b, rate_a, fault, lost} <= p;
      repeat (6) @(posedge clk_i);
   endtask

   task automatic adc_pulse(input logic ic);
      @(posedge clk_i);
      int_cal  <= ic;
      adc_done <= 1'b1;
      @(posedge clk_i);
      adc_done <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask

   task automatic test_done();
      $display("Counts: checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ==========================================
   // Watchdog
   initial begin
      repeat (80000) @(posedge clk_i);
      fail_count++;
      $display("MISMATCH %0t watchdog expired", $time);
      test_done();
   end

   // ==========================================
   // Test sequence
   initial begin
      clk_i = 1'b0;
      reset_n_i = 1'b0;
      slow = 1'b0;
      {tx_off, rate_b, rate_a, fault, lost, tx_soft, int_cal, adc_done} = '0;
      raw = 16'h1234;
      cal = 16'habcd;
      checked = 0;
      fail_count = 0;
      repeat (10) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);

      rdc(OFF_RXP_HIGH, 8'h00, "power high reset");
      rdc(OFF_RXP_LOW, 8'h00, "power low reset");
      rdc(OFF_CTRL, 8'h01, "ctrl reset");
      rdc(OFF_MODE, 8'h00, "mode reset");
      rdc(8'h70, 8'h00, "unmapped read");
      $display("Test reset values done");

      set_pins(5'b10111);
      rdc(OFF_CTRL, 8'h97, "pin view a");
      chk1(laser_off, 1'b1, "laser off by pin");
      set_pins(5'b01000);
      rdc(OFF_CTRL, 8'h21, "pin view b");
      set_pins(5'b00000);
      $display("Test pin status done");

      wr(OFF_CTRL, 8'hff);
      rdc(OFF_CTRL, 8'h49, "writable bits only");
      chk1(laser_off, 1'b1, "laser off by soft");
      chk1(rx_rate, 1'b1, "soft rate drives rx");
      wr(OFF_CTRL, 8'h00);
      chk1(laser_off, 1'b0, "laser on");
      chk1(rx_rate, 1'b0, "rx rate low");
      $display("Test soft bits done");

      slow = 1'b1;
      adc_pulse(1'b0);
      rdc(OFF_RXP_HIGH, 8'h12, "raw power high");
      rdc(OFF_RXP_LOW, 8'h34, "raw power low");
      wr(OFF_CTRL, 8'hb7);
      rdc(OFF_CTRL, 8'h00, "por cleared, ro bits");
      wr(OFF_RXP_HIGH, 8'h55);
      rdc(OFF_RXP_HIGH, 8'h12, "power read-only");
      adc_pulse(1'b1);
      rdc(OFF_RXP_HIGH, 8'hab, "cal power high");
      rdc(OFF_RXP_LOW, 8'hcd, "cal power low");
      slow = 1'b0;
      $display("Test conversion results done");

      for (int m = 0; m < 2; m++) begin
         wr(OFF_MODE, {1'b0, m[0], 6'h3f});
         rdc(OFF_MODE, {1'b0, m[0], 6'h3f}, "mode readback");
         for (int i = 0; i < 16; i++) begin
            @(posedge clk_i);
            rate_a  <= i[0];
            rate_b  <= i[1];
            tx_soft <= i[3];
            wr(OFF_CTRL, {4'h0, i[2], 3'h0});
            chk1(rx_rate, m[0] ? i[0] : (i[0] | i[2]), "rx rate");
            chk1(tx_rate, m[0] ? i[1] : i[3], "tx rate");
         end
      end
      $display("Test rate modes done");

      wr(OFF_MODE, 8'h80);
      @(posedge clk_i);
      {rate_a, rate_b, tx_soft} <= 3'b000;
      wr(OFF_CTRL, 8'h00);
      chk1(rx_rate, 1'b1, "sw mode rx hold");
      chk1(tx_rate, 1'b1, "sw mode tx hold");
      wr(OFF_MODE, 8'h40);
      wr(OFF_MODE, 8'hc0);
      @(posedge clk_i);
      {rate_a, rate_b, tx_soft} <= 3'b111;
      wr(OFF_CTRL, 8'h08);
      chk1(rx_rate, 1'b0, "sw mode rx ignores");
      chk1(tx_rate, 1'b0, "sw mode tx ignores");
      $display("Test software mode done");

      @(posedge clk_i);
      reset_n_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      chk1(rx_rate, 1'b1, "rx rate after reset");
      chk1(tx_rate, 1'b1, "tx rate after reset");
      rdc(OFF_MODE, 8'h00, "mode after reset");
      rdc(OFF_CTRL, 8'h31, "ctrl after reset");
      rdc(OFF_RXP_LOW, 8'h00, "power after reset");
      chk1(ack_ok, 1'b1, "all bytes acked");
      $display("Test mid-run reset done");
      test_done();
   end
endmodule
